/* File: rtl/tx_event_fifo_and_tx_queue.sv */
`timescale 1ns/1ps
`default_nettype none

module completion_fifo #(
    parameter int WIDTH = 37,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_check
        $error("completion_fifo: depth must be a power of two, at least 2");
    end

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0] wr_ptr_ff, rd_ptr_ff;
    logic [AW:0] count_ff;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    assign in_ready = (count_ff != (AW+1)'(DEPTH));
    assign out_valid = (count_ff != '0);
    assign out_data = mem_ff[rd_ptr_ff];

    always_ff @(posedge clock) begin
        if (push) begin
            mem_ff[wr_ptr_ff] <= in_data;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff <= '0;
        end else begin
            wr_ptr_ff <= wr_ptr_ff + AW'(push);
            rd_ptr_ff <= rd_ptr_ff + AW'(pop);
            count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// Function
// - depth field plus one sets buffer depth
// - reset bit resets buffer, hardware clears it
// - reset bit held in configuration, clears after
// - increment bit advances event tail by one
// - timestamp enable decides stamped event objects
// - sizing fields writable only in configuration
// - event enables gate flags onto interrupt
// - event full, half, not-empty flags track occupancy
// - overflow flag sticky until software clears
// - user address reads current tail address
// - retry field: none, three, unlimited
// - five-bit priority ranks the queue
// - send request clears after queue drained
// - writing zero while set requests abort
// - increment bit commits one queue message
// - transmit direction bit reads one
// - queue enables; exhausted attempts set flag
// - empty and not-full flags reset high
// - message index gives next slot sent
// - completion status updates; send or zero clears
module tx_event_fifo_and_tx_queue #(
    parameter int BUF_DEPTH = 16,
    parameter logic [31:0] EVENT_BASE = 32'h0000_0000
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // controller mode
    input wire logic config_mode,
    input wire logic global_retry_limit_enable,
    // register access
    input wire txlog_pkg::reg_req_s reg_req,
    output logic [31:0] reg_rdata,
    output logic reg_rvalid,
    // completions from the protocol engine
    input wire logic cmp_valid,
    output logic cmp_ready,
    input wire txlog_pkg::completion_s cmp_data,
    // queue towards the protocol engine
    output logic send_pending,
    output logic abort_pending,
    output logic [4:0] next_message_index,
    output logic [4:0] queue_priority,
    output logic [1:0] retry_limit,
    output logic [6:0] payload_size,
    // event object writes
    output logic evt_valid,
    output txlog_pkg::event_obj_s evt_data,
    // interrupt requests
    output logic event_irq,
    output logic queue_irq
);
    import txlog_pkg::*;

    // register decode
    wire wr_ectl = reg_req.wr && (reg_req.idx == REG_EVENT_CTRL);
    wire wr_esta = reg_req.wr && (reg_req.idx == REG_EVENT_STAT);
    wire wr_qctl = reg_req.wr && (reg_req.idx == REG_QUEUE_CTRL);
    wire wr_qsta = reg_req.wr && (reg_req.idx == REG_QUEUE_STAT);
    wire [31:0] wd = reg_req.wdata;

    // configuration fields
    logic [4:0] evt_depth_ff, q_depth_ff, q_prio_ff;
    logic [2:0] q_payload_ff;
    logic [1:0] q_retry_ff;
    logic ts_en_ff;
    logic [3:0] evt_ie_ff;
    logic [2:0] q_ie_ff;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            evt_depth_ff <= DEPTH_RST;
            ts_en_ff <= 1'b0;
            evt_ie_ff <= '0;
        end else if (wr_ectl) begin
            evt_ie_ff <= wd[OVF_BIT:NE_BIT];
            if (config_mode) begin
                evt_depth_ff <= wd[DEPTH_LSB +: 5];
                ts_en_ff <= wd[TS_EN_BIT];
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            q_depth_ff <= DEPTH_RST;
            q_payload_ff <= '0;
            q_retry_ff <= RETRY_RST;
            q_prio_ff <= '0;
            q_ie_ff <= '0;
        end else if (wr_qctl) begin
            q_retry_ff <= wd[RETRY_LSB +: 2];
            q_prio_ff <= wd[PRIO_LSB +: 5];
            q_ie_ff <= {wd[ATT_IE_BIT], wd[QE_BIT], wd[QNF_BIT]};
            if (config_mode) begin
                q_depth_ff <= wd[DEPTH_LSB +: 5];
                q_payload_ff <= wd[PAYLOAD_LSB +: 3];
            end
        end
    end

    // buffer reset bits: held in configuration, one cycle to reset in normal mode
    logic evt_rst_ff, q_rst_ff;
    wire nxt_evt_rst = config_mode || (wr_ectl && wd[RESET_BIT]);
    wire nxt_q_rst = config_mode || (wr_qctl && wd[RESET_BIT]);

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            evt_rst_ff <= 1'b1;
            q_rst_ff <= 1'b1;
        end else begin
            evt_rst_ff <= nxt_evt_rst;
            q_rst_ff <= nxt_q_rst;
        end
    end

    // completion buffer; drain stalls while either buffer resets
    completion_s rec;
    logic rec_valid;
    wire rec_ready = !evt_rst_ff && !q_rst_ff;
    wire take = rec_valid && rec_ready;

    completion_fifo #(.WIDTH($bits(completion_s)), .DEPTH(BUF_DEPTH)) u_cmp_fifo (
        .clock(clock),
        .rst_n(rst_n),
        .in_valid(cmp_valid),
        .in_ready(cmp_ready),
        .in_data(cmp_data),
        .out_valid(rec_valid),
        .out_ready(rec_ready),
        .out_data(rec)
    );

    // transmit event log occupancy
    logic [4:0] evt_head_ff, evt_tail_ff;
    logic [5:0] evt_count_ff;
    logic ovf_ff;
    wire [5:0] evt_depth = {1'b0, evt_depth_ff} + 6'h01;
    wire evt_full = (evt_count_ff == evt_depth);
    wire evt_half = ({evt_count_ff, 1'b0} >= {1'b0, evt_depth});
    wire evt_not_empty = (evt_count_ff != 6'h00);
    wire evt_take = take && rec.ok;
    wire evt_overflow = evt_take && evt_full;
    wire evt_push = evt_take && !evt_full;
    wire evt_pop = wr_ectl && wd[INC_BIT] && evt_not_empty && !evt_rst_ff;
    wire [31:0] evt_obj = ts_en_ff ? (OBJ_BYTES + STAMP_BYTES) : OBJ_BYTES;
    wire [31:0] evt_tail_addr = EVENT_BASE + 32'(evt_tail_ff) * evt_obj;
    wire [31:0] evt_head_addr = EVENT_BASE + 32'(evt_head_ff) * evt_obj;

    always_ff @(posedge clock) begin
        if (!rst_n || evt_rst_ff) begin
            evt_head_ff <= '0;
            evt_tail_ff <= '0;
            evt_count_ff <= '0;
        end else begin
            if (evt_push) begin
                evt_head_ff <= (evt_head_ff == evt_depth_ff) ? 5'h00 : evt_head_ff + 5'h01;
            end
            if (evt_pop) begin
                evt_tail_ff <= (evt_tail_ff == evt_depth_ff) ? 5'h00 : evt_tail_ff + 5'h01;
            end
            evt_count_ff <= evt_count_ff + 6'(evt_push) - 6'(evt_pop);
        end
    end

    // overflow flag: hardware set wins over software clear
    wire ovf_clr = wr_esta && !wd[OVF_BIT];

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ovf_ff <= 1'b0;
        end else if (evt_overflow) begin
            ovf_ff <= 1'b1;
        end else if (ovf_clr) begin
            ovf_ff <= 1'b0;
        end
    end

    // event object write, stamped only when enabled
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            evt_valid <= 1'b0;
            evt_data <= '0;
        end else begin
            evt_valid <= evt_push;
            if (evt_push) begin
                evt_data.addr <= evt_head_addr;
                evt_data.stamp <= ts_en_ff ? rec.stamp : 32'h0000_0000;
                evt_data.stamped <= ts_en_ff;
            end
        end
    end

    // transmit queue occupancy
    logic [4:0] q_head_ff, q_ci_ff;
    logic [5:0] q_count_ff;
    logic send_ff, abort_ff, abt_ff, larb_ff, err_ff, att_ff;
    wire [5:0] q_depth = {1'b0, q_depth_ff} + 6'h01;
    wire q_empty = (q_count_ff == 6'h00);
    wire q_not_full = (q_count_ff < q_depth);
    wire q_inc = wr_qctl && wd[INC_BIT] && q_not_full && !q_rst_ff;
    wire q_done = take && rec.ok && !q_empty;
    wire set_send = wr_qctl && wd[SEND_BIT] && !send_ff;
    wire abort_req = wr_qctl && !wd[SEND_BIT] && send_ff;
    wire last_sent = q_done && (q_count_ff == 6'h01) && !q_inc;

    always_ff @(posedge clock) begin
        if (!rst_n || q_rst_ff) begin
            q_head_ff <= '0;
            q_ci_ff <= '0;
            q_count_ff <= '0;
        end else begin
            if (q_inc) begin
                q_head_ff <= (q_head_ff == q_depth_ff) ? 5'h00 : q_head_ff + 5'h01;
            end
            if (q_done) begin
                q_ci_ff <= (q_ci_ff == q_depth_ff) ? 5'h00 : q_ci_ff + 5'h01;
            end
            q_count_ff <= q_count_ff + 6'(q_inc) - 6'(q_done);
        end
    end

    // send request and abort
    always_ff @(posedge clock) begin
        if (!rst_n || q_rst_ff) begin
            send_ff <= 1'b0;
            abort_ff <= 1'b0;
        end else begin
            if (set_send) begin
                send_ff <= 1'b1;
            end else if (abort_req || last_sent) begin
                send_ff <= 1'b0;
            end
            if (abort_req) begin
                abort_ff <= 1'b1;
            end else if (take || set_send) begin
                abort_ff <= 1'b0;
            end
        end
    end

    // completion status: a completion updates, send or a zero write clears
    always_ff @(posedge clock) begin
        if (!rst_n || q_rst_ff) begin
            abt_ff <= 1'b0;
            larb_ff <= 1'b0;
            err_ff <= 1'b0;
        end else if (take) begin
            abt_ff <= rec.aborted;
            larb_ff <= rec.lost_arb;
            err_ff <= rec.bus_err;
        end else begin
            abt_ff <= abt_ff && !set_send && !(wr_qsta && !wd[ABT_BIT]);
            larb_ff <= larb_ff && !set_send && !(wr_qsta && !wd[LARB_BIT]);
            err_ff <= err_ff && !set_send && !(wr_qsta && !wd[ERR_BIT]);
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            att_ff <= 1'b0;
        end else if (take && rec.exhausted) begin
            att_ff <= 1'b1;
        end else if (wr_qsta && !wd[ATT_FLAG_BIT]) begin
            att_ff <= 1'b0;
        end
    end

    // engine-facing outputs
    assign send_pending = send_ff && !q_empty && !config_mode;
    assign abort_pending = abort_ff;
    assign next_message_index = q_ci_ff;
    assign queue_priority = q_prio_ff;
    assign retry_limit = !global_retry_limit_enable ? RETRY_FOREVER :
        (q_retry_ff == 2'b00) ? RETRY_NONE :
        (q_retry_ff == 2'b01) ? RETRY_THREE : RETRY_FOREVER;
    assign payload_size = payload_bytes(q_payload_ff);

    // interrupt gating
    wire [3:0] evt_flags = {ovf_ff, evt_full, evt_half, evt_not_empty};
    wire [2:0] q_flags = {att_ff, q_empty, q_not_full};
    assign event_irq = |(evt_flags & evt_ie_ff);
    assign queue_irq = |(q_flags & q_ie_ff);

    // read views
    wire [31:0] rd_ectl = {3'h0, evt_depth_ff, 13'h0, evt_rst_ff, 2'h0, 2'h0, ts_en_ff,
        1'b0, evt_ie_ff};
    wire [31:0] rd_esta = {28'h0, evt_flags};
    wire [31:0] rd_qctl = {q_payload_ff, q_depth_ff, 1'b0, q_retry_ff, q_prio_ff, 5'h0,
        q_rst_ff, send_ff, 1'b0, 1'b1, 2'h0, q_ie_ff[2], 1'b0, q_ie_ff[1], 1'b0,
        q_ie_ff[0]};
    wire [31:0] rd_qsta = {19'h0, q_ci_ff, abt_ff, larb_ff, err_ff, att_ff, 1'b0, q_empty,
        1'b0, q_not_full};
    wire [31:0] rd_sel = (reg_req.idx == REG_EVENT_CTRL) ? rd_ectl :
        (reg_req.idx == REG_EVENT_STAT) ? rd_esta :
        (reg_req.idx == REG_EVENT_UA) ? evt_tail_addr :
        (reg_req.idx == REG_QUEUE_CTRL) ? rd_qctl :
        (reg_req.idx == REG_QUEUE_STAT) ? rd_qsta : 32'h0000_0000;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            reg_rdata <= '0;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_req.rd;
            if (reg_req.rd) begin
                reg_rdata <= rd_sel;
            end
        end
    end

    // checks
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    a_reset_in_config: assert property (config_mode |=> evt_rst_ff && q_rst_ff)
        else $error("reset bits not held in configuration");
    a_reset_empties: assert property (evt_rst_ff && !nxt_evt_rst |=>
        !evt_rst_ff && evt_count_ff == 6'h00)
        else $error("event log reset did not finish");
    a_depth_bound: assert property (evt_count_ff <= evt_depth && q_count_ff <= q_depth)
        else $error("occupancy beyond depth");
    a_tail_advance: assert property (evt_pop && !evt_push |=>
        evt_count_ff == $past(evt_count_ff) - 6'h01)
        else $error("increment did not consume one entry");
    a_overflow_sticky: assert property (evt_overflow && !evt_pop |=>
        ovf_ff && evt_count_ff == $past(evt_count_ff))
        else $error("overflow not flagged or entry stored");
    a_config_lock: assert property (!config_mode |=> $stable(evt_depth_ff) &&
        $stable(q_depth_ff) && $stable(q_payload_ff) && $stable(ts_en_ff))
        else $error("sizing changed outside configuration");
    a_send_done: assert property (send_ff && last_sent && !wr_qctl && !q_rst_ff |=>
        !send_ff)
        else $error("send request not cleared after last message");
    a_abort_req: assert property (abort_req && !q_rst_ff |=> abort_pending && !send_ff)
        else $error("abort not taken");
    a_status_clear: assert property (set_send && !take && !q_rst_ff |=> !abt_ff)
        else $error("status not cleared on send");
    a_queue_reset_flags: assert property (q_rst_ff |=> q_empty && q_not_full)
        else $error("queue flags wrong after reset");
    a_irq_gate: assert property (ovf_ff && evt_ie_ff[3] |-> event_irq)
        else $error("overflow interrupt not raised");

    c_overflow: cover property (evt_overflow);
    c_abort: cover property (abort_req ##[1:20] take);
    c_queue_drained: cover property (last_sent);
    c_tail_pop: cover property (evt_push ##[1:10] evt_pop);
endmodule

`default_nettype wire

/* File: rtl/txlog_pkg.sv */
package txlog_pkg;

    // register indices on the register access port
    localparam logic [2:0] REG_EVENT_CTRL = 3'h0;
    localparam logic [2:0] REG_EVENT_STAT = 3'h1;
    localparam logic [2:0] REG_EVENT_UA = 3'h2;
    localparam logic [2:0] REG_QUEUE_CTRL = 3'h3;
    localparam logic [2:0] REG_QUEUE_STAT = 3'h4;

    // control register fields
    localparam int PAYLOAD_LSB = 29;
    localparam int DEPTH_LSB = 24;
    localparam int RETRY_LSB = 21;
    localparam int PRIO_LSB = 16;
    localparam int RESET_BIT = 10;
    localparam int SEND_BIT = 9;
    localparam int INC_BIT = 8;
    localparam int DIR_BIT = 7;
    localparam int TS_EN_BIT = 5;
    localparam int ATT_IE_BIT = 4;
    localparam int OVF_BIT = 3;
    localparam int FULL_BIT = 2;
    localparam int HALF_BIT = 1;
    localparam int NE_BIT = 0;
    localparam int QE_BIT = 2;
    localparam int QNF_BIT = 0;

    // queue status fields
    localparam int INDEX_LSB = 8;
    localparam int ABT_BIT = 7;
    localparam int LARB_BIT = 6;
    localparam int ERR_BIT = 5;
    localparam int ATT_FLAG_BIT = 4;

    // reset values
    localparam logic [1:0] RETRY_RST = 2'h3;
    localparam logic [4:0] DEPTH_RST = 5'h00;

    // event object sizes in bytes
    localparam logic [31:0] OBJ_BYTES = 32'h0000_0008;
    localparam logic [31:0] STAMP_BYTES = 32'h0000_0004;

    typedef enum logic [1:0] {
        RETRY_NONE = 2'b00,
        RETRY_THREE = 2'b01,
        RETRY_FOREVER = 2'b10
    } retry_mode_e;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [2:0] idx;
        logic [31:0] wdata;
    } reg_req_s;

    typedef struct packed {
        logic ok;
        logic aborted;
        logic lost_arb;
        logic bus_err;
        logic exhausted;
        logic [31:0] stamp;
    } completion_s;

    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] stamp;
        logic stamped;
    } event_obj_s;

    function automatic logic [6:0] payload_bytes(input logic [2:0] code);
        case (code)
            3'h0: payload_bytes = 7'h08;
            3'h1: payload_bytes = 7'h0c;
            3'h2: payload_bytes = 7'h10;
            3'h3: payload_bytes = 7'h14;
            3'h4: payload_bytes = 7'h18;
            3'h5: payload_bytes = 7'h20;
            3'h6: payload_bytes = 7'h30;
            default: payload_bytes = 7'h40;
        endcase
    endfunction

endpackage

/* File: sim/engine_model.sv */
`timescale 1ns/1ps
`default_nettype none

module engine_model
    import txlog_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // command from the bench
    input wire logic go,
    input wire txlog_pkg::completion_s rec,
    input wire logic [3:0] gap,
    output logic busy,
    // completion stream
    output logic cmp_valid,
    input wire logic cmp_ready,
    output txlog_pkg::completion_s cmp_data
);
    logic [3:0] wait_ff;
    completion_s hold_ff;

    // record held until the edge that sees ready; idle data toggles so it is never stale
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            busy <= 1'b0;
            cmp_valid <= 1'b0;
            cmp_data <= '0;
        end else if (go && !busy) begin
            busy <= 1'b1;
            wait_ff <= gap;
            hold_ff <= rec;
            cmp_data <= ~cmp_data;
        end else if (busy && !cmp_valid) begin
            if (wait_ff == 4'h0) begin
                cmp_valid <= 1'b1;
                cmp_data <= hold_ff;
            end else begin
                cmp_data <= ~cmp_data;
            end
            wait_ff <= wait_ff - 4'h1;
        end else if (cmp_valid && cmp_ready) begin
            cmp_valid <= 1'b0;
            busy <= 1'b0;
            cmp_data <= ~cmp_data;
        end else if (!busy) begin
            cmp_data <= ~cmp_data;
        end
    end
endmodule

`default_nettype wire

/* File: sim/tb.sv */
`timescale 1ns/1ps
`default_nettype none

module tb;
    import txlog_pkg::*;
    logic clock, rst_n, config_mode, glob_en, cmp_valid, cmp_ready, reg_rvalid;
    logic go, busy, send_pending, abort_pending, evt_valid, event_irq, queue_irq;
    reg_req_s reg_req;
    logic [31:0] reg_rdata, qc;
    completion_s cmp_data, rec;
    event_obj_s evt_data;
    logic [3:0] gap;
    logic [4:0] next_message_index, queue_priority, pr;
    logic [1:0] retry_limit, rt;
    logic [6:0] payload_size;
    int n_fail, cmp_count, n_evt, seed;
    logic ts_on;

    tx_event_fifo_and_tx_queue #(.BUF_DEPTH(16), .EVENT_BASE(32'h0000_0100)) dut (
        .clock(clock), .rst_n(rst_n), .config_mode(config_mode),
        .global_retry_limit_enable(glob_en), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .cmp_valid(cmp_valid), .cmp_ready(cmp_ready),
        .cmp_data(cmp_data), .send_pending(send_pending), .abort_pending(abort_pending),
        .next_message_index(next_message_index), .queue_priority(queue_priority),
        .retry_limit(retry_limit), .payload_size(payload_size), .evt_valid(evt_valid),
        .evt_data(evt_data), .event_irq(event_irq), .queue_irq(queue_irq));

    engine_model partner (.clock(clock), .rst_n(rst_n), .go(go), .rec(rec), .gap(gap),
        .busy(busy), .cmp_valid(cmp_valid), .cmp_ready(cmp_ready), .cmp_data(cmp_data));

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    function automatic logic [31:0] exp_bytes(input int code);
        int t[8] = '{8, 12, 16, 20, 24, 32, 48, 64};
        return t[code];
    endfunction

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [2:0] idx, input logic [31:0] d);
        reg_req = '{1'b1, 1'b0, idx, d};
        @(posedge clock); #1;
        reg_req.wr = 1'b0;
        @(posedge clock); #1;
    endtask

    task automatic rd(input logic [2:0] idx, input logic [31:0] exp, input string what);
        reg_req = '{1'b0, 1'b1, idx, 32'h0};
        @(posedge clock); #1;
        reg_req.rd = 1'b0;
        chk(what, exp, reg_rdata);
        chk("read valid", 32'h1, {31'h0, reg_rvalid});
        @(posedge clock); #1;
    endtask

    // one completion record from the engine, prompt or slow at random
    task automatic fire(input logic ok, input logic [3:0] flags);
        rec = '{ok, flags[3], flags[2], flags[1], flags[0], $random(seed)};
        gap = 4'($random(seed));
        go = 1'b1;
        @(posedge clock); #1;
        go = 1'b0;
        for (int i = 0; i < 40 && busy; i++) begin
            @(posedge clock); #1;
        end
        chk("completion taken", 32'h0, {31'h0, busy});
        repeat (3) @(posedge clock);
        #1;
    endtask

    // event object writes land at the next head slot, twelve bytes apart with stamps
    always @(posedge clock) begin
        if (evt_valid === 1'b1) begin
            chk("event addr", 32'h100 + (n_evt % 4) * (ts_on ? 12 : 8), evt_data.addr);
            chk("event stamped", {31'h0, ts_on}, {31'h0, evt_data.stamped});
            chk("event stamp", ts_on ? rec.stamp : 32'h0, evt_data.stamp);
            n_evt++;
        end
    end

    task automatic stop_test;
        $display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        repeat (4000) @(posedge clock);
        n_fail++;
        stop_test();
    end

    initial begin
        seed = 8101;
        rst_n = 1'b0;
        config_mode = 1'b1;
        glob_en = 1'b1;
        reg_req = '0;
        go = 1'b0;
        rec = '0;
        gap = 4'h0;
        n_fail = 0;
        cmp_count = 0;
        n_evt = 0;
        ts_on = 1'b1;
        repeat (4) @(posedge clock);
        #1;
        rst_n = 1'b1;
        rd(REG_QUEUE_CTRL, 32'h0060_0480, "queue ctrl reset");
        rd(REG_QUEUE_STAT, 32'h0000_0005, "queue status reset");
        rd(REG_EVENT_CTRL, 32'h0000_0400, "event ctrl reset");
        for (int i = 0; i < 8; i++) begin
            pr = 5'($random(seed));
            rt = 2'(i);
            glob_en = i[2];
            qc = {3'(i), 5'h03, 1'b0, rt, pr, 16'h0};
            wr(REG_QUEUE_CTRL, qc);
            chk("payload size", exp_bytes(i), {25'h0, payload_size});
            chk("priority", {27'h0, pr}, {27'h0, queue_priority});
            chk("retry", (glob_en && !rt[1]) ? rt : 2'h2, {30'h0, retry_limit});
        end
        rd(REG_QUEUE_CTRL, qc | 32'h480, "queue ctrl config");
        wr(REG_EVENT_CTRL, 32'h0300_0020);
        config_mode = 1'b0;
        repeat (3) @(posedge clock);
        #1;
        rd(REG_EVENT_CTRL, 32'h0300_0020, "event reset cleared");
        wr(REG_EVENT_CTRL, 32'h1f00_0000);
        rd(REG_EVENT_CTRL, 32'h0300_0020, "event sizing locked");
        for (int i = 0; i < 5; i++) begin
            wr(REG_QUEUE_CTRL, qc | 32'h100);
        end
        rd(REG_QUEUE_STAT, 32'h0, "queue full");
        wr(REG_QUEUE_CTRL, qc | 32'h200);
        chk("send pending", 32'h1, {31'h0, send_pending});
        for (int i = 0; i < 4; i++) begin
            chk("message index", i, {27'h0, next_message_index});
            fire(1'b1, 4'h0);
        end
        rd(REG_QUEUE_CTRL, qc | 32'h80, "send cleared");
        rd(REG_QUEUE_STAT, 32'h0000_0005, "queue drained");
        rd(REG_EVENT_STAT, 32'h0000_0007, "event log full");
        fire(1'b1, 4'h0);
        chk("events written", 32'h4, 32'(n_evt));
        rd(REG_EVENT_STAT, 32'h0000_000f, "overflow set");
        wr(REG_EVENT_CTRL, 32'h0300_0028);
        chk("event irq", 32'h1, {31'h0, event_irq});
        wr(REG_EVENT_STAT, 32'h0);
        chk("event irq masked", 32'h0, {31'h0, event_irq});
        rd(REG_EVENT_UA, 32'h0000_0100, "tail address");
        wr(REG_EVENT_CTRL, 32'h0300_0129);
        rd(REG_EVENT_UA, 32'h0000_010c, "tail advanced");
        rd(REG_EVENT_STAT, 32'h0000_0003, "event log three");
        chk("event irq not empty", 32'h1, {31'h0, event_irq});
        wr(REG_QUEUE_CTRL, qc | 32'h100);
        wr(REG_QUEUE_CTRL, qc | 32'h200);
        wr(REG_QUEUE_CTRL, qc);
        chk("abort pending", 32'h1, {31'h0, abort_pending});
        fire(1'b0, 4'h8);
        chk("abort dropped", 32'h0, {31'h0, abort_pending});
        rd(REG_QUEUE_STAT, 32'h0000_0081, "aborted status");
        rt = 2'($random(seed));
        fire(1'b0, {1'b0, rt, 1'b1});
        rd(REG_QUEUE_STAT, {25'h0, rt, 5'h11}, "exhausted status");
        wr(REG_QUEUE_CTRL, qc | 32'h10);
        chk("queue irq", 32'h1, {31'h0, queue_irq});
        wr(REG_QUEUE_STAT, 32'h0);
        rd(REG_QUEUE_STAT, 32'h0000_0001, "status cleared");
        chk("queue irq cleared", 32'h0, {31'h0, queue_irq});
        // software buffer reset in normal mode, then stamps off through configuration
        wr(REG_EVENT_CTRL, 32'h0300_0409);
        rd(REG_EVENT_CTRL, 32'h0300_0029, "event reset done");
        rd(REG_EVENT_STAT, 32'h0, "event log reset");
        config_mode = 1'b1;
        wr(REG_EVENT_CTRL, 32'h0300_0000);
        rd(REG_EVENT_CTRL, 32'h0300_0400, "reset held in config");
        config_mode = 1'b0;
        ts_on = 1'b0;
        repeat (2) @(posedge clock);
        #1;
        for (int i = 0; i < 2; i++) begin
            fire(1'b1, 4'h0);
        end
        rd(REG_EVENT_STAT, 32'h0000_0003, "event log two");
        rd(REG_EVENT_UA, 32'h0000_0100, "tail after reset");
        stop_test();
    end
endmodule

`default_nettype wire
